// ---- rtl/fidp_host.sv ----
// host controller that drives the parallel flash command interface
`timescale 1ns/100ps
// What this block does
// - identification command then reading offsets 0 and 1 gives maker/part codes.
// - leave identification mode only by writing the reset sequence.
// - page program always begins with two unlocks then A0H.
// - each load is a write strobe pulse with select low, output strobe high.
// - page of 128 bytes or 64 words; page bits fixed across loads; here bits 19:6 fix the page, so byte mode gets 64 bytes.
// - next load falls within 30us of the previous rising edge; left to the user, not timed here.
// - host user should erase the page sector first; not enforced here.
// - program refused while program fail bit set; clear status first.
module fidp_host
	import fidp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic cmd_valid,
	input wire fidp_op_type cmd_op,
	input wire logic [19:0] cmd_addr,
	input wire logic [15:0] cmd_value,
	input wire logic cmd_word_mode,
	input wire logic cmd_last,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic rsp_refused,
	output logic [19:0] flash_addr,
	output logic flash_byte_n,
	output logic chip_select_a_n,
	output logic chip_select_b_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe_n,
	input wire logic [15:0] flash_dq_in
);
	fidp_state_type state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [2:0] step_reg;
	logic [2:0] nsteps_reg;
	logic in_page_reg;
	logic busy_reg;
	logic fail_reg;
	logic [13:0] page_reg;
	logic [15:0] dq_s1_reg, dq_s2_reg, dq_s3_reg;
	fidp_op_type op_reg;
	logic [19:0] addr_reg;
	logic [15:0] val_reg;
	logic cmd_last_reg;
	logic word_reg;
	logic [15:0] dq_stable_reg;

	// pin data counts only once the last two synchroniser stages agree
	wire dq_settled = dq_s2_reg == dq_s3_reg;
	wire go = cmd_valid && cmd_ready;
	// program refused while fail latched; during run only status is accepted
	wire refuse = (cmd_op == FIDP_OP_PROGRAM && fail_reg) ||
		(busy_reg && cmd_op != FIDP_OP_STATUS) ||
		(in_page_reg && cmd_op != FIDP_OP_PROGRAM);
	wire is_read = (cmd_op == FIDP_OP_READ) && !in_page_reg;
	// unlock sequence prefix for every op except read; program loads after prefix skip it
	wire prefix_needed = !(op_reg == FIDP_OP_READ) && !(op_reg == FIDP_OP_PROGRAM && in_page_reg);

	function automatic logic [7:0] cmd_code(input fidp_op_type op);
		case (op)
			FIDP_OP_RESET: cmd_code = CMD_RESET;
			FIDP_OP_ID: cmd_code = CMD_ID;
			FIDP_OP_PROGRAM: cmd_code = CMD_PROGRAM;
			FIDP_OP_CLEAR: cmd_code = CMD_CLEAR_STATUS;
			FIDP_OP_STATUS: cmd_code = CMD_READ_STATUS;
			default: cmd_code = CMD_RESET;
		endcase
	endfunction : cmd_code

	// step 0..2 are the unlock prefix; step 3 is the data load of a program
	wire [19:0] step_addr = (step_reg == 3'd1) ? {5'h00, UNLOCK_ADDR_B} :
		(step_reg == 3'd3 || !prefix_needed) ? addr_reg : {5'h00, UNLOCK_ADDR_A};
	wire [15:0] step_data = (step_reg == 3'd0) ? {8'h00, UNLOCK_DATA_A} :
		(step_reg == 3'd1) ? {8'h00, UNLOCK_DATA_B} :
		(step_reg == 3'd2) ? {8'h00, cmd_code(op_reg)} :
		(word_reg ? val_reg : {8'h00, val_reg[7:0]});
	wire more_steps = (step_reg + 3'd1) < nsteps_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			FIDP_IDLE: if (go && !refuse) state_next = is_read ? FIDP_READ : FIDP_LOW;
			FIDP_LOW: if (cnt_reg == '0) state_next = FIDP_HIGH;
			FIDP_HIGH: begin
				if (cnt_reg == '0) begin
					if (more_steps) state_next = FIDP_LOW;
					else if (op_reg == FIDP_OP_PROGRAM) state_next = cmd_last_reg ? FIDP_CLOSE : FIDP_GAP;
					else if (op_reg == FIDP_OP_STATUS) state_next = FIDP_READ;
					else state_next = FIDP_DONE;
				end
			end
			FIDP_READ: if (cnt_reg == '0) state_next = busy_reg ? FIDP_POLL : FIDP_DONE;
			// a load is answered at once so the user can keep the next one inside the gap
			FIDP_GAP: state_next = FIDP_DONE;
			// after the silent window the device shows status without any command
			FIDP_CLOSE: if (cnt_reg == '0) state_next = FIDP_READ;
			FIDP_POLL: state_next = dq_stable_reg[DONE_FLAG_POS] ? FIDP_DONE : FIDP_READ;
			FIDP_DONE: state_next = FIDP_IDLE;
			default: state_next = FIDP_IDLE;
		endcase
	end

	wire [CNT_W-1:0] cnt_load = (state_next == FIDP_LOW) ? CNT_W'(STROBE_LOW_CYC) :
		(state_next == FIDP_HIGH) ? CNT_W'(STROBE_HIGH_CYC) :
		(state_next == FIDP_READ) ? CNT_W'(READ_CYC) :
		(state_next == FIDP_CLOSE) ? CNT_W'(CLOSE_CYC) : '0;
	wire load_cnt = state_next != state_reg || state_next == FIDP_LOW && state_reg == FIDP_HIGH;
	// the strobe falls one cycle after select so the address has set up first
	wire drive_we = state_reg == FIDP_LOW && cnt_reg != CNT_W'(STROBE_LOW_CYC);
	wire drive_sel = state_reg == FIDP_LOW || state_reg == FIDP_HIGH || state_reg == FIDP_READ;
	wire last_load_done = state_reg == FIDP_HIGH && cnt_reg == '0 && !more_steps && op_reg == FIDP_OP_PROGRAM;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_reg <= FIDP_IDLE;
			cnt_reg <= '0;
			step_reg <= '0;
			nsteps_reg <= '0;
			op_reg <= FIDP_OP_READ;
			addr_reg <= '0;
			val_reg <= '0;
			in_page_reg <= 1'b0;
			busy_reg <= 1'b0;
			fail_reg <= 1'b0;
			page_reg <= '0;
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= '0;
			rsp_refused <= 1'b0;
			dq_s1_reg <= '0;
			dq_s2_reg <= '0;
			dq_s3_reg <= '0;
			dq_stable_reg <= '0;
			word_reg <= 1'b0;
		end else begin
			dq_s1_reg <= flash_dq_in;
			dq_s2_reg <= dq_s1_reg;
			dq_s3_reg <= dq_s2_reg;
			if (dq_settled) begin
				dq_stable_reg <= dq_s3_reg;
			end
			state_reg <= state_next;
			cnt_reg <= load_cnt ? cnt_load : (cnt_reg == '0 ? cnt_reg : cnt_reg - 1'b1);
			cmd_ready <= state_next == FIDP_IDLE;
			rsp_valid <= state_reg == FIDP_DONE || (go && refuse);
			rsp_refused <= go && refuse;
			if (go && !refuse) begin
				op_reg <= cmd_op;
				addr_reg <= cmd_addr;
				val_reg <= cmd_value;
				step_reg <= (cmd_op == FIDP_OP_PROGRAM && in_page_reg) ? 3'd3 : 3'd0;
				nsteps_reg <= (cmd_op == FIDP_OP_PROGRAM) ? 3'd4 : (cmd_op == FIDP_OP_READ) ? 3'd1 : 3'd3;
				// the page is taken as erased; erasing its sector first is left to the user
				if (cmd_op == FIDP_OP_PROGRAM && !in_page_reg) page_reg <= cmd_addr[19:6];
				// width is latched once per page so later loads cannot switch it midway
				if (!(cmd_op == FIDP_OP_PROGRAM && in_page_reg)) word_reg <= cmd_word_mode;
				if (cmd_op == FIDP_OP_CLEAR) fail_reg <= 1'b0;
			end else if (state_reg == FIDP_HIGH && cnt_reg == '0 && more_steps) begin
				step_reg <= step_reg + 3'd1;
			end
			// a program load opens the page; the last load flagged by the user closes it
			if (last_load_done) begin
				in_page_reg <= !cmd_last_reg;
				busy_reg <= cmd_last_reg;
			end
			if (state_reg == FIDP_POLL && dq_stable_reg[DONE_FLAG_POS]) begin
				busy_reg <= 1'b0;
				if (dq_stable_reg[PROGRAM_FAIL_POS]) fail_reg <= 1'b1;
			end
			if (state_reg == FIDP_READ && cnt_reg == '0) rsp_data <= dq_stable_reg;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) cmd_last_reg <= 1'b0;
		else if (go && !refuse) cmd_last_reg <= cmd_last;
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			flash_addr <= '0;
			flash_byte_n <= 1'b0;
			chip_select_a_n <= 1'b1;
			chip_select_b_n <= 1'b1;
			flash_oe_n <= 1'b1;
			flash_we_n <= 1'b1;
			flash_dq_out <= '0;
			flash_dq_oe_n <= 1'b1;
		end else begin
			// address and data stay put around the whole strobe pulse
			flash_addr <= (op_reg == FIDP_OP_PROGRAM && step_reg == 3'd3) ? {page_reg, addr_reg[5:0]} : step_addr;
			flash_byte_n <= word_reg;
			chip_select_a_n <= !drive_sel;
			chip_select_b_n <= !drive_sel;
			flash_oe_n <= !(state_reg == FIDP_READ);
			flash_we_n <= !drive_we;
			flash_dq_out <= step_data;
			flash_dq_oe_n <= !(state_reg == FIDP_LOW || state_reg == FIDP_HIGH);
		end
	end
endmodule : fidp_host

// ---- rtl/fidp_pkg.sv ----
// package: constants for the flash command-side host controller
package fidp_pkg;
	localparam int CLK_MHZ = 200;
	localparam logic [14:0] UNLOCK_ADDR_A = 15'h5555;
	localparam logic [14:0] UNLOCK_ADDR_B = 15'h2AAA;
	localparam logic [7:0] UNLOCK_DATA_A = 8'hAA;
	localparam logic [7:0] UNLOCK_DATA_B = 8'h55;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [7:0] CMD_ID = 8'h90;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam int DONE_FLAG_POS = 7;
	localparam int PROGRAM_FAIL_POS = 4;
	localparam logic [3:0] SECTOR_BOTTOM = 4'h0;
	localparam logic [3:0] SECTOR_TOP = 4'hF;
	localparam int PAGE_BYTES = 128;
	localparam int PAGE_WORDS = 64;
	// bus cycle timing (ns and us) and derived cycle counts
	localparam int T_STROBE_LOW_NS = 60;
	localparam int T_STROBE_HIGH_NS = 40;
	localparam int T_READ_NS = 120;
	localparam int T_LOAD_GAP_US = 30;
	localparam int T_CLOSE_US = 100;
	localparam int STROBE_LOW_CYC = (T_STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_HIGH_CYC = (T_STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int READ_CYC = (T_READ_NS * CLK_MHZ + 999) / 1000;
	localparam int LOAD_GAP_CYC = T_LOAD_GAP_US * CLK_MHZ;
	localparam int CLOSE_CYC = T_CLOSE_US * CLK_MHZ;
	localparam int CNT_W = 16;
	typedef enum logic [3:0] {
		FIDP_IDLE = 4'h0,
		FIDP_LOW = 4'h1,
		FIDP_HIGH = 4'h3,
		FIDP_READ = 4'h2,
		FIDP_GAP = 4'h6,
		FIDP_CLOSE = 4'h7,
		FIDP_POLL = 4'h5,
		FIDP_DONE = 4'h4
	} fidp_state_type;
	typedef enum logic [2:0] {
		FIDP_OP_READ = 3'h0,
		FIDP_OP_RESET = 3'h1,
		FIDP_OP_ID = 3'h2,
		FIDP_OP_PROGRAM = 3'h3,
		FIDP_OP_CLEAR = 3'h4,
		FIDP_OP_STATUS = 3'h5
	} fidp_op_type;
endpackage : fidp_pkg

// ---- tb/fidp_flash_model.sv ----
// behavioural model of the flash command interface facing the host
`timescale 1ns/100ps
module fidp_flash_model
	import fidp_pkg::*;
#(
	parameter logic [7:0] MAKER = 8'h00,
	parameter logic [7:0] PART = 8'h00
)
(
	input wire logic [19:0] flash_addr,
	input wire logic flash_byte_n,
	input wire logic chip_select_a_n,
	input wire logic chip_select_b_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic [15:0] flash_dq_out,
	output logic [15:0] flash_dq_in
);
	// md: 0 array, 1 id, 2 status, 3 page load
	int md = 0;
	int st = 0;
	logic [19:0] la;
	logic wm = 1'b1;
	logic [7:0] d;
	realtime tr = 0;
	logic [15:0] mem[int];
	logic [15:0] pg[int];
	logic [15:0] q;
	wire sel = !chip_select_a_n && !chip_select_b_n;
	// only the top sector reads as protected here; the bottom one reads unprotected
	wire top_sector = flash_addr[19:16] == SECTOR_TOP;
	always @(negedge flash_we_n) if (sel) begin
		la = flash_addr;
		if (st == 2) wm = flash_byte_n;
	end
	always @(posedge flash_we_n) if (sel) begin
		d = flash_dq_out[7:0];
		if (md == 3) begin
			pg[la] = wm ? flash_dq_out : {8'h00, d};
			tr = $realtime;
		end else if (st == 0 && la[14:0] == UNLOCK_ADDR_A && d == UNLOCK_DATA_A) st = 1;
		else if (st == 1 && la[14:0] == UNLOCK_ADDR_B && d == UNLOCK_DATA_B) st = 2;
		else if (st == 2) begin
			st = 0;
			md = d == CMD_ID ? 1 : d == CMD_RESET ? 0 : d == CMD_PROGRAM ? 3 : d == CMD_READ_STATUS ? 2 : md;
		end else st = 0;
	end
	// programming is instant once the load window closes
	always #1000 if (md == 3 && tr > 0 && $realtime - tr > 100000) begin
		foreach (pg[k]) mem[k] = pg[k];
		pg.delete();
		md = 2;
		tr = 0;
	end
	always @* case (md)
		1: q = {8'h00, flash_addr[1] ? (top_sector ? MAKER : 8'h00) : flash_addr[0] ? PART : MAKER};
		2, 3: q = {8'h00, md == 2, 7'h00};
		default: q = mem.exists(flash_addr) ? mem[flash_addr] : 16'hFFFF;
	endcase
	// released bus shows the inverse so a stale value can never pass
	assign flash_dq_in = (sel && !flash_oe_n && flash_we_n) ? q : ~q;
endmodule : fidp_flash_model

// ---- tb/fidp_host_properties.sv ----
// checker for pin timing of the flash host controller
`timescale 1ns/100ps
module fidp_host_properties
	import fidp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic rsp_valid,
	input wire logic rsp_refused,
	input wire logic [19:0] flash_addr,
	input wire logic chip_select_a_n,
	input wire logic chip_select_b_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic [15:0] flash_dq_out,
	input wire logic flash_dq_oe_n
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	sequence low_12;
		(!flash_we_n)[*8] ##1 (!flash_we_n)[*4] ##1 flash_we_n;
	endsequence
	chk_read_no_drive: assert property (!flash_oe_n |-> flash_we_n && flash_dq_oe_n)
		else $error("read strobe with write or drive");
	chk_select_pair: assert property (chip_select_a_n == chip_select_b_n)
		else $error("chip selects differ");
	chk_write_qual: assert property (!flash_we_n |-> flash_oe_n && !flash_dq_oe_n && !chip_select_a_n)
		else $error("write strobe without select or drive");
	chk_addr_setup: assert property ($fell(flash_we_n) |-> $stable(flash_addr))
		else $error("address moved at strobe fall");
	chk_data_hold: assert property ($rose(flash_we_n) |-> $stable(flash_dq_out))
		else $error("data moved at strobe rise");
	chk_strobe_width: assert property ($fell(flash_we_n) |-> low_12)
		else $error("write strobe width wrong");
	chk_unlock_upper: assert property (!flash_we_n && flash_addr[14:0] == UNLOCK_ADDR_B |-> flash_addr[19:15] == 5'h00)
		else $error("unlock address upper bits set");
	chk_refuse_pulse: assert property (rsp_refused |-> rsp_valid ##1 !rsp_valid)
		else $error("refusal without single response");
endmodule : fidp_host_properties
bind fidp_host fidp_host_properties chk (.ref_clk, .nrst, .rsp_valid, .rsp_refused, .flash_addr, .chip_select_a_n,
	.chip_select_b_n, .flash_oe_n, .flash_we_n, .flash_dq_out, .flash_dq_oe_n);

// ---- tb/test_fidp_host.sv ----
// testbench for the flash host controller
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; $display("FAIL %0t mismatch %h %h", $time, a, b); end end
module test_fidp_host
	import fidp_pkg::*;
;
	localparam logic [7:0] MAKER = 8'h3C; // arbitrary
	localparam logic [7:0] PART = 8'h5A; // arbitrary
	logic ref_clk = 0, nrst = 0, cmd_valid = 0, cmd_word_mode = 1, cmd_last = 0;
	fidp_op_type cmd_op = FIDP_OP_READ;
	logic [19:0] cmd_addr = 0, flash_addr;
	logic [15:0] cmd_value = 0, rsp_data, flash_dq_out, flash_dq_in, got;
	logic cmd_ready, rsp_valid, rsp_refused, refd, flash_byte_n, chip_select_a_n, chip_select_b_n;
	logic flash_oe_n, flash_we_n, flash_dq_oe_n;
	int error_cnt = 0, total_checks = 0;
	always #2.5 ref_clk = ~ref_clk;
	fidp_host dut (.ref_clk, .nrst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_value, .cmd_word_mode, .cmd_last,
		.cmd_ready, .rsp_valid, .rsp_data, .rsp_refused, .flash_addr, .flash_byte_n, .chip_select_a_n,
		.chip_select_b_n, .flash_oe_n, .flash_we_n, .flash_dq_out, .flash_dq_oe_n, .flash_dq_in);
	fidp_flash_model #(.MAKER(MAKER), .PART(PART)) flash (.flash_addr, .flash_byte_n, .chip_select_a_n,
		.chip_select_b_n, .flash_oe_n, .flash_we_n, .flash_dq_out, .flash_dq_in);
	task automatic finish_test;
		if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test
	task automatic req(input fidp_op_type op, input logic [19:0] a, input logic [15:0] v, input logic l);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 40000) begin @(posedge ref_clk) #1; n++; end
		cmd_valid = 1;
		cmd_op = op;
		cmd_addr = a;
		cmd_value = v;
		cmd_last = l;
		@(posedge ref_clk) #1;
		cmd_valid = 0;
		while (rsp_valid !== 1'b1 && n < 40000) begin @(posedge ref_clk) #1; n++; end
		got = rsp_data;
		refd = rsp_refused;
		if (n >= 40000) begin error_cnt++; finish_test(); end
	endtask : req
	task automatic t_array;
		req(FIDP_OP_READ, 20'h00010, 16'h0000, 0);
		`CHK(got, 16'hFFFF)
		`CHK(refd, 1'b0)
	endtask : t_array
	task automatic t_id;
		req(FIDP_OP_ID, 20'h00000, 16'h0000, 0);
		req(FIDP_OP_READ, 20'h00000, 16'h0000, 0);
		`CHK(got, {8'h00, MAKER})
		req(FIDP_OP_READ, 20'h00001, 16'h0000, 0);
		`CHK(got, {8'h00, PART})
		req(FIDP_OP_READ, 20'hF0002, 16'h0000, 0);
		`CHK(got, {8'h00, MAKER})
		req(FIDP_OP_READ, 20'h00002, 16'h0000, 0);
		`CHK(got, 16'h0000)
		req(FIDP_OP_RESET, 20'h00000, 16'h0000, 0);
		req(FIDP_OP_READ, 20'h00001, 16'h0000, 0);
		`CHK(got, 16'hFFFF)
	endtask : t_id
	// loads out of order, a refused read mid-page, then status and readback
	task automatic t_prog;
		req(FIDP_OP_PROGRAM, 20'h12345, 16'h1234, 0);
		req(FIDP_OP_READ, 20'h12345, 16'h0000, 0);
		`CHK(refd, 1'b1)
		req(FIDP_OP_PROGRAM, 20'h12340, 16'hBEEF, 1);
		`CHK(got, 16'h0080)
		`CHK(refd, 1'b0)
		req(FIDP_OP_STATUS, 20'h00000, 16'h0000, 0);
		`CHK(got[7], 1'b1)
		req(FIDP_OP_RESET, 20'h00000, 16'h0000, 0);
		req(FIDP_OP_READ, 20'h12345, 16'h0000, 0);
		`CHK(got, 16'h1234)
		req(FIDP_OP_READ, 20'h12340, 16'h0000, 0);
		`CHK(got, 16'hBEEF)
		req(FIDP_OP_READ, 20'h12341, 16'h0000, 0);
		`CHK(got, 16'hFFFF)
	endtask : t_prog
	initial begin
		repeat (4) @(posedge ref_clk);
		#1 nrst = 1;
		t_array();
		t_id();
		t_prog();
		finish_test();
	end
endmodule : test_fidp_host
